// ### hw/upd_consts.svh
// Offsets, field positions and reset values of the descriptor map block
`ifndef UPD_CONSTS_SVH
`define UPD_CONSTS_SVH
`define UPD_OFS_CFG 12'h000
`define UPD_OFS_PPRST 12'h004
`define UPD_OFS_XSTAT 12'h008
`define UPD_OFS_SFLAG 12'h00c
`define UPD_OFS_SENA 12'h010
`define UPD_OFS_SCLR 12'h014
`define UPD_OFS_EFLAG 12'h018
`define UPD_OFS_EENA 12'h01c
`define UPD_OFS_ECLR 12'h020
`define UPD_OFS_PFLAG 12'h024
`define UPD_OFS_DESC 12'h400
`define UPD_CFG_RST 8'h00
`define UPD_CFG_EN_BIT 3
`define UPD_ST_OWN 7
`define UPD_ST_TOG 6
`define UPD_ST_TCE 3
`define UPD_ST_STALL 2
`define UPD_SFL_ERR 1
`define UPD_SFL_TRN 3
`define UPD_PFL_USB 4
`endif

// ### hw/upd_pkg.sv
// Types shared by the descriptor map block
package upd_pkg;
    typedef enum logic [1:0] {
        UPD_PP_NONE,
        UPD_PP_EP0_OUT,
        UPD_PP_ALL,
        UPD_PP_ALL_BUT0
    } upd_mode_e;
    typedef logic [5:0] upd_desc_t;
    typedef logic [3:0] upd_ep_t;
endpackage : upd_pkg

// ### hw/upd_core.sv
// Ping-pong descriptor table, pointer tracking and interrupt funnel
`timescale 1ns/1ps
`include "upd_consts.svh"

// Overview of operation
// - Ping-pong endpoints own even and odd descriptors
// - Two-bit mode field selects buffering mode
// - Per-endpoint pointers, reset even on enable
// - Engine completion toggles a ping-pong endpoint's pointer
// - Transfer status shows last even/odd parity
// - Pointer reset bit forces all pointers even
// - Modes 0 and 1 descriptor numbering
// - Modes 2 and 3 descriptor numbering
// - 64 descriptors of four unreset bytes
// - Status byte layout differs by owner
// - Engine overwrites toggle-check and stall settings
// - Data toggle ignored without toggle check
// - Two interrupt layers; errors set summary
// - All sources but status events 1 and 7 funnel into bit 4 request
// - Ownership bit one means engine owns
module upd_core (
    // Bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Engine lookup and completion
    input wire logic eng_req,
    input wire upd_pkg::upd_ep_t eng_ep,
    input wire logic eng_dir_in,
    output upd_pkg::upd_desc_t eng_desc,
    output logic [7:0] eng_stat,
    output logic [7:0] eng_cnt,
    output logic [15:0] eng_addr,
    output logic eng_tog_check,
    output logic eng_stall,
    input wire logic eng_done,
    input wire logic [3:0] eng_pid,
    input wire logic [9:0] eng_count,
    // Event sources
    input wire logic [7:0] stat_evt,
    input wire logic [7:0] err_evt,
    // Interrupt
    output logic usb_irq_request
);
    import upd_pkg::*;

    // ----------------------------------------
    // Descriptor mapping
    // ----------------------------------------
    // descriptor numbering
    function automatic upd_desc_t desc_of(input upd_mode_e m, input upd_ep_t ep,
                                          input logic din, input logic odd);
        logic [6:0] n;
        n = {3'h0, ep};
        unique case (m)
            UPD_PP_NONE: desc_of = upd_desc_t'({n[5:0], din});
            UPD_PP_EP0_OUT: desc_of = (ep == 4'h0) ? (din ? 6'h02 : {5'h00, odd})
                                                   : upd_desc_t'(2 * n + 7'(din) + 7'h01);
            UPD_PP_ALL: desc_of = {ep, din, odd};
            UPD_PP_ALL_BUT0: desc_of = (ep == 4'h0) ? {5'h00, din}
                : upd_desc_t'(4 * n + 7'(2 * din) + 7'(odd) - 7'h02);
        endcase
    endfunction : desc_of

    function automatic logic is_pp(input upd_mode_e m, input upd_ep_t ep, input logic din);
        unique case (m)
            UPD_PP_NONE: is_pp = 1'b0;
            UPD_PP_EP0_OUT: is_pp = (ep == 4'h0) && !din;
            UPD_PP_ALL: is_pp = 1'b1;
            UPD_PP_ALL_BUT0: is_pp = (ep != 4'h0);
        endcase
    endfunction : is_pp

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic ph_valid_r;
    logic ph_write_r;
    logic [11:0] ph_addr_r;
    logic [7:0] cfg_r;
    logic [7:0] sflag_r;
    logic [7:0] sena_r;
    logic [7:0] eflag_r;
    logic [7:0] eena_r;
    logic [7:0] xstat_r;
    logic [31:0] pp_r;
    logic [7:0] st_mem [0:63];
    logic [7:0] cnt_mem [0:63];
    logic [7:0] adl_mem [0:63];
    logic [7:0] adh_mem [0:63];
    upd_mode_e mode;
    logic mod_en;
    logic en_d_r;
    logic wr_go;
    logic [7:0] wbyte;
    logic eng_odd;
    upd_desc_t cur_desc;
    logic done_pp;
    logic [4:0] done_idx;
    logic err_any;
    logic [7:0] sflag_nxt;

    assign mode = upd_mode_e'(cfg_r[1:0]);
    assign mod_en = cfg_r[`UPD_CFG_EN_BIT];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_go = clk_en && ph_valid_r && ph_write_r;
    assign wbyte = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 12'h000;
        end else if (clk_en && hready) begin
            ph_valid_r <= hsel && htrans[1];
            ph_write_r <= hwrite;
            ph_addr_r <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= `UPD_CFG_RST;
            sena_r <= 8'h00;
            eena_r <= 8'h00;
        end else if (wr_go) begin
            if (ph_addr_r == `UPD_OFS_CFG) cfg_r <= wbyte;
            if (ph_addr_r == `UPD_OFS_SENA) sena_r <= wbyte;
            if (ph_addr_r == `UPD_OFS_EENA) eena_r <= wbyte;
        end
    end

    // Reads come straight from storage; unmapped words below the descriptor table read zero, those above it alias a descriptor
    always_comb begin
        hrdata = 32'h0000_0000;
        if (ph_addr_r >= `UPD_OFS_DESC) begin
            hrdata = {adh_mem[ph_addr_r[9:4]], adl_mem[ph_addr_r[9:4]],
                      cnt_mem[ph_addr_r[9:4]], st_mem[ph_addr_r[9:4]]};
        end else begin
            unique case (ph_addr_r)
                `UPD_OFS_CFG: hrdata = {24'h0, cfg_r};
                `UPD_OFS_XSTAT: hrdata = {24'h0, xstat_r};
                `UPD_OFS_SFLAG: hrdata = {24'h0, sflag_r};
                `UPD_OFS_SENA: hrdata = {24'h0, sena_r};
                `UPD_OFS_EFLAG: hrdata = {24'h0, eflag_r};
                `UPD_OFS_EENA: hrdata = {24'h0, eena_r};
                `UPD_OFS_PFLAG: hrdata = {27'h0, usb_irq_request, 4'h0};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Descriptor table
    // ----------------------------------------
    // engine side lookup uses current pointer
    assign eng_odd = pp_r[{eng_ep, eng_dir_in}];
    assign cur_desc = desc_of(mode, eng_ep, eng_dir_in,
                              is_pp(mode, eng_ep, eng_dir_in) && eng_odd);
    assign done_pp = is_pp(mode, eng_ep, eng_dir_in);
    assign done_idx = {eng_ep, eng_dir_in};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eng_desc <= 6'h00;
            eng_stat <= 8'h00;
            eng_cnt <= 8'h00;
            eng_addr <= 16'h0000;
            eng_tog_check <= 1'b0;
            eng_stall <= 1'b0;
        end else if (clk_en && eng_req) begin
            eng_desc <= cur_desc;
            eng_stat <= st_mem[cur_desc];
            eng_cnt <= cnt_mem[cur_desc];
            eng_addr <= {adh_mem[cur_desc], adl_mem[cur_desc]};
            // toggle only meaningful with check on
            eng_tog_check <= st_mem[cur_desc][`UPD_ST_TCE];
            eng_stall <= st_mem[cur_desc][`UPD_ST_STALL];
        end
    end

    always_ff @(posedge hclk) begin
        if (clk_en) begin
            if (wr_go && ph_addr_r >= `UPD_OFS_DESC) begin
                st_mem[ph_addr_r[9:4]] <= wbyte & 8'hcf;
                cnt_mem[ph_addr_r[9:4]] <= hwdata[15:8];
                adl_mem[ph_addr_r[9:4]] <= hwdata[23:16];
                adh_mem[ph_addr_r[9:4]] <= hwdata[31:24];
            end
            // Engine write-back comes last, so it beats a same-cycle bus write to the status and count bytes
            if (eng_done) begin
                // engine returns PID, hands back ownership
                st_mem[cur_desc] <= {1'b0, st_mem[cur_desc][`UPD_ST_TOG], eng_pid,
                                     eng_count[9:8]};
                cnt_mem[cur_desc] <= eng_count[7:0];
            end
        end
    end

    // ----------------------------------------
    // Ping-pong pointers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_d_r <= 1'b0;
        end else if (clk_en) begin
            en_d_r <= mod_en;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pp_r <= 32'h0000_0000;
        end else if (clk_en) begin
            // enable edge or reset bit forces even
            if ((mod_en && !en_d_r) || (wr_go && ph_addr_r == `UPD_OFS_PPRST && wbyte[0])) begin
                pp_r <= 32'h0000_0000;
            end else if (eng_done && done_pp) begin
                pp_r[done_idx] <= !pp_r[done_idx];
            end
        end
    end

    // endpoint, direction and parity of last completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xstat_r <= 8'h00;
        end else if (clk_en && eng_done) begin
            xstat_r <= {1'b0, eng_ep, eng_dir_in, done_pp && eng_odd, 1'b0};
        end
    end

    // ----------------------------------------
    // Interrupt funnel
    // ----------------------------------------
    // Set wins over a clear written in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eflag_r <= 8'h00;
        end else if (clk_en) begin
            eflag_r <= (eflag_r & ~((wr_go && ph_addr_r == `UPD_OFS_ECLR) ? wbyte : 8'h00))
                       | err_evt;
        end
    end

    // summary flag follows enabled errors only
    assign err_any = |(eflag_r & eena_r);

    always_comb begin
        sflag_nxt = sflag_r & ~((wr_go && ph_addr_r == `UPD_OFS_SCLR) ? wbyte : 8'h00);
        sflag_nxt = sflag_nxt | stat_evt;
        if (eng_done) sflag_nxt[`UPD_SFL_TRN] = 1'b1;
        sflag_nxt[`UPD_SFL_ERR] = err_any;
        sflag_nxt[7] = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sflag_r <= 8'h00;
        end else if (clk_en) begin
            sflag_r <= sflag_nxt;
        end
    end

    assign usb_irq_request = |(sflag_r & sena_r);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_pp_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && eng_done && done_pp && !(mod_en && !en_d_r) && !wr_go
        |=> pp_r[$past(done_idx)] != $past(pp_r[done_idx]))
        else $error("pointer did not toggle");
    a_single_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && eng_done && !done_pp && !wr_go && !(mod_en && !en_d_r)
        |=> pp_r == $past(pp_r))
        else $error("single buffer pointer moved");
    a_enable_even: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && mod_en && !en_d_r |=> pp_r == 32'h0000_0000)
        else $error("pointers not even after enable");
    a_rst_even: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_go && ph_addr_r == `UPD_OFS_PPRST && wbyte[0] |=> pp_r == 32'h0000_0000)
        else $error("pointer reset ignored");
    a_parity_show: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && eng_done |=> xstat_r[1] == $past(done_pp && eng_odd))
        else $error("parity indicator wrong");
    a_err_summary: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && err_any |=> sflag_r[`UPD_SFL_ERR])
        else $error("error summary not set");
    a_irq_funnel: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && eng_done && sena_r[`UPD_SFL_TRN] && !wr_go |=> usb_irq_request)
        else $error("interrupt request missing");
    a_map_mode2: assert property (@(posedge hclk) disable iff (!hresetn)
        mode == UPD_PP_ALL |-> cur_desc == {eng_ep, eng_dir_in, eng_odd})
        else $error("mode 2 mapping wrong");
    a_own_back: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && eng_done |=> !st_mem[$past(cur_desc)][`UPD_ST_OWN])
        else $error("ownership not returned");
    // Spot checks of the fixed descriptor slots
    a_map_none: assert property (@(posedge hclk) disable iff (!hresetn)
        mode == UPD_PP_NONE |-> cur_desc == {1'b0, eng_ep, eng_dir_in})
        else $error("mode 0 mapping wrong");
    a_map_ep0in: assert property (@(posedge hclk) disable iff (!hresetn)
        mode == UPD_PP_EP0_OUT && eng_ep == 4'h0 && eng_dir_in |-> cur_desc == 6'h02)
        else $error("mode 1 endpoint 0 IN mapping wrong");
    a_map_mode3: assert property (@(posedge hclk) disable iff (!hresetn)
        mode == UPD_PP_ALL_BUT0 && eng_ep == 4'h0 |-> cur_desc == {5'h00, eng_dir_in})
        else $error("mode 3 endpoint 0 mapping wrong");
    a_pid_back: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && eng_done |=> st_mem[$past(cur_desc)][5:2] == $past(eng_pid))
        else $error("token id not returned");
    a_lookup_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !(clk_en && eng_req) |=> $stable(eng_desc))
        else $error("lookup result moved without request");
    a_freeze_ptr: assert property (@(posedge hclk) disable iff (!hresetn)
        !clk_en |=> pp_r == $past(pp_r))
        else $error("pointers moved while frozen");
    a_trn_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && eng_done |=> sflag_r[`UPD_SFL_TRN])
        else $error("transaction flag not set");
    a_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        sena_r == 8'h00 |-> !usb_irq_request)
        else $error("request with nothing enabled");
endmodule : upd_core

// ### tb/upd_eng_model.sv
// Engine-side partner: descriptor lookups and completion write-backs
`timescale 1ns/1ps
module upd_eng_model (
    // Clock
    input wire logic hclk,
    // Engine requests
    output logic eng_req,
    output upd_pkg::upd_ep_t eng_ep,
    output logic eng_dir_in,
    output logic eng_done,
    output logic [3:0] eng_pid,
    output logic [9:0] eng_count
);
    import upd_pkg::*;
    initial begin
        eng_req = 1'b0;
        eng_ep = 4'h0;
        eng_dir_in = 1'b0;
        eng_done = 1'b0;
        eng_pid = 4'h0;
        eng_count = 10'h000;
    end
    task automatic lookup(input upd_ep_t ep, input logic dir);
        eng_req <= 1'b1;
        eng_ep <= ep;
        eng_dir_in <= dir;
        @(posedge hclk);
        eng_req <= 1'b0;
        @(posedge hclk);
    endtask : lookup
    task automatic complete(input logic [3:0] pid, input logic [9:0] cnt, input int gap);
        repeat (gap) @(posedge hclk);
        eng_done <= 1'b1;
        eng_pid <= pid;
        eng_count <= cnt;
        @(posedge hclk);
        eng_done <= 1'b0;
        // Released lines show the inverse, not a stale copy
        eng_pid <= ~pid;
        eng_count <= ~cnt;
        @(posedge hclk);
    endtask : complete
endmodule : upd_eng_model

// ### tb/usb_pingpong_descriptor_map_test.sv
// Self-checking bench of the descriptor map block
`timescale 1ns/1ps
`include "upd_consts.svh"
module usb_pingpong_descriptor_map_test;
    import upd_pkg::*;
    logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans, mode;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, ptr, rd;
    logic eng_req, eng_dir_in, eng_done, eng_tog_check, eng_stall, usb_irq_request;
    upd_ep_t eng_ep;
    upd_desc_t eng_desc;
    logic [3:0] eng_pid;
    logic [9:0] eng_count;
    logic [7:0] eng_stat, eng_cnt, stat_evt, err_evt, v;
    logic [15:0] eng_addr;
    int checks, num_errors;
    assign hready = hreadyout;
    upd_core dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .eng_req(eng_req), .eng_ep(eng_ep), .eng_dir_in(eng_dir_in), .eng_desc(eng_desc),
        .eng_stat(eng_stat), .eng_cnt(eng_cnt), .eng_addr(eng_addr),
        .eng_tog_check(eng_tog_check), .eng_stall(eng_stall), .eng_done(eng_done),
        .eng_pid(eng_pid), .eng_count(eng_count), .stat_evt(stat_evt), .err_evt(err_evt),
        .usb_irq_request(usb_irq_request));
    upd_eng_model u_eng (.hclk(hclk), .eng_req(eng_req), .eng_ep(eng_ep),
        .eng_dir_in(eng_dir_in), .eng_done(eng_done), .eng_pid(eng_pid),
        .eng_count(eng_count));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    function automatic logic [5:0] exp_desc(logic [1:0] m, logic [3:0] e, logic d, logic o);
        case (m)
            2'd0: return {1'b0, e, d};
            2'd1: return (e == 4'h0) ? (d ? 6'd2 : {5'd0, o}) : {1'b0, e, d} + 6'd1;
            2'd2: return {e, d, o};
            default: return (e == 4'h0) ? {5'd0, d} : {e, d, o} - 6'd2;
        endcase
    endfunction : exp_desc
    function automatic logic pp_on(logic [1:0] m, logic [3:0] e, logic d);
        return m == 2'd2 || (m == 2'd1 && e == 4'h0 && !d) || (m == 2'd3 && e != 4'h0);
    endfunction : pp_on
    // Hand a descriptor over, look it up, complete it and read everything back
    task automatic step(input upd_ep_t e, input logic d);
        logic o;
        logic [11:0] a;
        logic [31:0] w;
        logic [3:0] pid;
        logic [9:0] cnt;
        o = pp_on(mode, e, d) & ptr[{e, d}];
        a = `UPD_OFS_DESC + {exp_desc(mode, e, d, o), 4'h0};
        w = ($urandom | 32'h80) & ~32'h30;
        pid = 4'($urandom);
        cnt = 10'($urandom);
        xfer(1'b1, a, w);
        u_eng.lookup(e, d);
        chk(eng_desc, exp_desc(mode, e, d, o));
        chk(eng_stat, w[7:0]);
        chk({eng_tog_check, eng_stall}, w[3:2]);
        chk({eng_addr, eng_cnt}, w[31:8]);
        u_eng.complete(pid, cnt, $urandom_range(0, 3));
        ptr[{e, d}] ^= pp_on(mode, e, d);
        xfer(1'b0, `UPD_OFS_XSTAT, 32'h0);
        chk(rd, {e, d, o, 1'b0});
        xfer(1'b0, a, 32'h0);
        chk(rd, {w[31:16], cnt[7:0], 1'b0, w[6], pid, cnt[9:8]});
    endtask : step
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge hclk);
        chk(usb_irq_request, e);
    endtask : chk_irq
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, stat_evt, err_evt} = '0;
        {clk_en, hsize, checks, num_errors, ptr} = {1'b1, 3'b010, 96'h0};
        void'($urandom(32'h823e));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, `UPD_OFS_CFG, 32'h0);
        chk(rd, `UPD_CFG_RST);
        xfer(1'b1, 12'h0fc, 32'hffff_ffff);
        xfer(1'b0, 12'h0fc, 32'h0);
        chk(rd, 32'h0);
        chk(hresp, 1'b0);
        chk(hreadyout, 1'b1);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            xfer(1'b1, `UPD_OFS_CFG, 32'h0);
            xfer(1'b1, `UPD_OFS_CFG, 32'h08 | m);
            ptr = '0;
            for (int i = 0; i < 32; i++) begin
                step(i[4:1], i[0]);
                step(i[4:1], i[0]);
            end
        end
        $display("test mapping done");
        for (int k = 0; k < 40; k++) begin
            if ($urandom_range(0, 4) == 0) begin
                xfer(1'b1, `UPD_OFS_PPRST, 32'h1);
                ptr = '0;
            end
            step(4'($urandom), 1'($urandom));
        end
        $display("test random done");
        xfer(1'b1, `UPD_OFS_SCLR, 32'hff);
        xfer(1'b1, `UPD_OFS_SENA, 32'h08);
        chk_irq(1'b0);
        step(4'h2, 1'b1);
        chk_irq(1'b1);
        xfer(1'b0, `UPD_OFS_PFLAG, 32'h0);
        chk(rd[4], 1'b1);
        xfer(1'b1, `UPD_OFS_SCLR, 32'h08);
        chk_irq(1'b0);
        xfer(1'b1, `UPD_OFS_EENA, 32'h01);
        err_evt <= 8'h03;
        @(posedge hclk);
        err_evt <= 8'h00;
        xfer(1'b0, `UPD_OFS_EFLAG, 32'h0);
        chk(rd, 32'h03);
        xfer(1'b0, `UPD_OFS_SFLAG, 32'h0);
        chk(rd, 32'h02);
        chk_irq(1'b0);
        xfer(1'b1, `UPD_OFS_SENA, 32'h02);
        chk_irq(1'b1);
        xfer(1'b1, `UPD_OFS_ECLR, 32'h01);
        chk_irq(1'b0);
        v = 8'($urandom) & 8'h75;
        stat_evt <= v;
        @(posedge hclk);
        stat_evt <= 8'h00;
        xfer(1'b0, `UPD_OFS_SFLAG, 32'h0);
        chk(rd, v);
        clk_en <= 1'b0;
        stat_evt <= ~v & 8'h75;
        @(posedge hclk);
        clk_en <= 1'b1;
        stat_evt <= 8'h00;
        xfer(1'b0, `UPD_OFS_SFLAG, 32'h0);
        chk(rd, v);
        $display("test interrupts done");
        final_report();
    end
    initial begin
        repeat (30000) @(posedge hclk);
        num_errors++;
        final_report();
    end
endmodule : usb_pingpong_descriptor_map_test
